// >>> src/iec_pkg.sv
// constants, types and vector tables shared by the interrupt/exception controller
`default_nettype none
package iec_pkg;
   localparam int N_EXT       = 8;
   localparam int N_INT       = 59;
   localparam int N_MSK       = 67;
   localparam int N_SRC_TOTAL = 69;
   localparam int N_LVL       = 8;
   localparam int LVL_W       = 3;
   localparam int SRC_W       = 7;

   localparam logic [15:0] CODE_RESET    = 16'h0000;
   localparam logic [15:0] CODE_WDT      = 16'h0020;
   localparam logic [15:0] CODE_NMI      = 16'h0030;
   localparam logic [15:0] CODE_TRAP_LO  = 16'h0040;
   localparam logic [15:0] CODE_TRAP_HI  = 16'h0050;
   localparam logic [15:0] CODE_ILLOP    = 16'h0060;
   localparam logic [15:0] CODE_MSK_BASE = 16'h0080;
   localparam logic [15:0] CODE_MSK_STEP = 16'h0010;

   localparam logic [31:0] HND_RESET   = 32'h0000_0000;
   localparam logic [31:0] HND_WDT     = 32'h0000_0020;
   localparam logic [31:0] HND_NMI     = 32'h0000_0030;
   localparam logic [31:0] HND_TRAP_LO = 32'h0000_0040;
   localparam logic [31:0] HND_TRAP_HI = 32'h0000_0050;
   localparam logic [31:0] HND_ILLOP   = 32'h0000_0060;

   localparam logic [LVL_W-1:0] LVL_RESET = 3'h7;
   localparam logic [N_LVL-1:0] ISR_RESET = 8'h00;

   localparam int CLK_PERIOD_NS = 4;
   localparam int FILTER_NS     = 20;
   localparam int FILTER_CYC    = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILTER_W      = $clog2(FILTER_CYC + 1);

   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   typedef enum logic [5:0] {
      KIND_RESET = 6'b000001,
      KIND_ILLOP = 6'b000010,
      KIND_TRAP  = 6'b000100,
      KIND_WDT   = 6'b001000,
      KIND_NMI   = 6'b010000,
      KIND_MSK   = 6'b100000
   } iec_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_OFFER = 2'b10
   } iec_state_t;

   function automatic logic [15:0] iec_msk_code(input logic [SRC_W-1:0] idx);
      iec_msk_code = CODE_MSK_BASE + 16'(idx) * CODE_MSK_STEP;
   endfunction
endpackage
`default_nettype wire

// >>> src/iec_edge_filt.sv
// noise filter and selectable edge detector for one request pin
`default_nettype none
module iec_edge_filt
   import iec_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       pin_i,
   input  wire logic [1:0] edge_sel_i,
   output logic            event_o
);
   logic                stable_r;
   logic [FILTER_W-1:0] cnt_r;
   logic                changed;
   logic                rise;

   assign changed = (pin_i != stable_r) && (cnt_r == FILTER_W'(FILTER_CYC - 1));
   assign rise    = ~stable_r;

   // a pulse shorter than the filter window never reaches the stable level
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stable_r <= 1'b0;
         cnt_r    <= '0;
      end else if (pin_i == stable_r) begin
         cnt_r <= '0;
      end else if (changed) begin
         stable_r <= pin_i;
         cnt_r    <= '0;
      end else begin
         cnt_r <= cnt_r + FILTER_W'(1);
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         event_o <= 1'b0;
      end else begin
         case (edge_sel_i)
            EDGE_RISE: event_o <= changed & rise;
            EDGE_FALL: event_o <= changed & ~rise;
            EDGE_BOTH: event_o <= changed;
            default:   event_o <= 1'b0;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> src/iec_prio_arb.sv
// picks the maskable request with the best programmed level
`default_nettype none
module iec_prio_arb
   import iec_pkg::*;
(
   input  wire logic [N_MSK-1:0]       req_i,
   input  wire logic [N_MSK*LVL_W-1:0] prio_i,
   output logic                        win_vld_o,
   output logic [SRC_W-1:0]            win_idx_o,
   output logic [LVL_W-1:0]            win_lvl_o
);
   always_comb begin
      win_vld_o = 1'b0;
      win_idx_o = '0;
      win_lvl_o = LVL_RESET;
      // walk downward with <= so the lowest index wins a tie
      for (int i = N_MSK - 1; i >= 0; i--) begin
         if (req_i[i] && (!win_vld_o || prio_i[i*LVL_W +: LVL_W] <= win_lvl_o)) begin
            win_vld_o = 1'b1;
            win_idx_o = SRC_W'(i);
            win_lvl_o = prio_i[i*LVL_W +: LVL_W];
         end
      end
   end
endmodule
`default_nettype wire

// >>> src/iec_interrupt_arbiter.sv
// interrupt and exception controller top: pending, nesting and vectoring
// Function
// - sixty-nine interrupt request sources serviced
// - eight external and fifty-nine internal maskable inputs
// - eight programmable priority levels drive arbitration
// - higher level preempts lower level handler
// - individual mask blocks each maskable request
// - pin noise filter, edge detect, edge select
// - reset vectors to zero, code zero
// - watchdog and pin non-maskable vectors
// - two software trap groups with nibble
// - illegal opcode or debug trap vector
// - low-voltage request is maskable source zero
// - external pins zero-seven follow low-voltage
// - interrupts and exceptions share one vectoring
`default_nettype none
module iec_interrupt_arbiter
   import iec_pkg::*;
(
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     soft_reset_i,
   input  wire logic                     low_voltage_request_i,
   input  wire logic [N_INT-2:0]         periph_req_i,
   input  wire logic [N_EXT-1:0]         ext_pin_i,
   input  wire logic [N_EXT*2-1:0]       ext_edge_sel_i,
   input  wire logic                     nmi_pin_i,
   input  wire logic [1:0]               nmi_edge_sel_i,
   input  wire logic                     watchdog_overflow_request_i,
   input  wire logic                     trap_i,
   input  wire logic [4:0]               trap_vec_i,
   input  wire logic                     illegal_opcode_exception_i,
   input  wire logic                     debug_exception_i,
   input  wire logic [N_MSK-1:0]         mask_i,
   input  wire logic [N_MSK*LVL_W-1:0]   prio_i,
   input  wire logic                     int_enable_i,
   input  wire logic                     ack_i,
   input  wire logic                     eoi_i,
   output logic                          exc_req_o,
   output logic [15:0]                   exc_code_o,
   output logic [31:0]                   handler_addr_o,
   output logic                          exc_is_intr_o,
   output logic                          pc_valid_o,
   output logic [N_LVL-1:0]              isr_o
);
   iec_state_t          state_r;
   iec_kind_t           kind_r;
   iec_kind_t           kind_nxt;
   logic [15:0]         code_nxt;
   logic [31:0]         hnd_nxt;
   logic                cand_vld;
   logic [SRC_W-1:0]    idx_r;
   logic [LVL_W-1:0]    lvl_r;

   logic                reset_pend_r;
   logic                illop_pend_r;
   logic                trap_pend_r;
   logic [4:0]          trap_vec_r;
   logic                wdt_pend_r;
   logic                nmi_pend_r;
   logic [N_MSK-1:0]    msk_pend_r;
   logic [N_LVL-1:0]    isr_r;

   logic [N_EXT-1:0]    ext_evt;
   logic                nmi_evt;
   logic [N_MSK-1:0]    msk_set;
   logic [N_MSK-1:0]    msk_clr;
   logic [N_MSK-1:0]    msk_elig;
   logic                win_vld;
   logic [SRC_W-1:0]    win_idx;
   logic [LVL_W-1:0]    win_lvl;
   logic [LVL_W:0]      isr_top;
   logic                msk_ok;
   logic                taken;
   logic [N_LVL-1:0]    isr_low;

   // handshake and per-kind retire strobes
   iec_state_t          state_nxt;
   logic                offer;
   logic                clr_reset;
   logic                clr_illop;
   logic                clr_trap;
   logic                clr_wdt;
   logic                clr_nmi;
   logic                clr_msk;
   logic [N_LVL-1:0]    isr_set;
   logic [N_LVL-1:0]    isr_clr;

   // every pin has its own filter and its own edge select
   genvar g;
   generate
      for (g = 0; g < N_EXT; g++) begin : g_ext
         iec_edge_filt u_filt (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .pin_i      (ext_pin_i[g]),
            .edge_sel_i (ext_edge_sel_i[g*2 +: 2]),
            .event_o    (ext_evt[g])
         );
      end
   endgenerate

   iec_edge_filt u_nmi_filt (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .pin_i      (nmi_pin_i),
      .edge_sel_i (nmi_edge_sel_i),
      .event_o    (nmi_evt)
   );

   // index 0 low voltage, 1..8 pins, then the other peripherals
   assign msk_set = {periph_req_i, ext_evt, low_voltage_request_i};
   assign msk_elig = msk_pend_r & ~mask_i & {N_MSK{int_enable_i}};

   // arbiter only sees eligible requests, so masks never reach it
   iec_prio_arb u_arb (
      .req_i     (msk_elig),
      .prio_i    (prio_i),
      .win_vld_o (win_vld),
      .win_idx_o (win_idx),
      .win_lvl_o (win_lvl)
   );

   // best level currently in service; N_LVL when none
   always_comb begin
      isr_top = (LVL_W + 1)'(N_LVL);
      for (int i = N_LVL - 1; i >= 0; i--) begin
         if (isr_r[i]) begin
            isr_top = (LVL_W + 1)'(i);
         end
      end
   end

   assign msk_ok = win_vld && ({1'b0, win_lvl} < isr_top);
   assign isr_low = isr_r & ~(isr_r - N_LVL'(1));

   // synchronous exceptions rank above the asynchronous non-maskables
   always_comb begin
      cand_vld = 1'b1;
      kind_nxt = KIND_RESET;
      code_nxt = CODE_RESET;
      hnd_nxt  = HND_RESET;
      if (reset_pend_r) begin
         kind_nxt = KIND_RESET;
      end else if (illop_pend_r) begin
         kind_nxt = KIND_ILLOP;
         code_nxt = CODE_ILLOP;
         hnd_nxt  = HND_ILLOP;
      end else if (trap_pend_r) begin
         kind_nxt = KIND_TRAP;
         code_nxt = (trap_vec_r[4] ? CODE_TRAP_HI : CODE_TRAP_LO) | {12'h000, trap_vec_r[3:0]};
         hnd_nxt  = trap_vec_r[4] ? HND_TRAP_HI : HND_TRAP_LO;
      end else if (wdt_pend_r) begin
         kind_nxt = KIND_WDT;
         code_nxt = CODE_WDT;
         hnd_nxt  = HND_WDT;
      end else if (nmi_pend_r) begin
         kind_nxt = KIND_NMI;
         code_nxt = CODE_NMI;
         hnd_nxt  = HND_NMI;
      end else if (msk_ok) begin
         kind_nxt = KIND_MSK;
         code_nxt = iec_msk_code(win_idx);
         hnd_nxt  = {16'h0000, iec_msk_code(win_idx)};
      end else begin
         cand_vld = 1'b0;
      end
   end

   // handshake decode stays combinational so the ack edge itself retires
   assign taken = (state_r == ST_OFFER) && ack_i;
   assign offer = cand_vld && !taken && !soft_reset_i;

   // an ack retires exactly the kind that stood on offer at that edge
   assign clr_reset = taken && (kind_r == KIND_RESET);
   assign clr_illop = taken && (kind_r == KIND_ILLOP);
   assign clr_trap  = taken && (kind_r == KIND_TRAP);
   assign clr_wdt   = taken && (kind_r == KIND_WDT);
   assign clr_nmi   = taken && (kind_r == KIND_NMI);
   assign clr_msk   = taken && (kind_r == KIND_MSK);

   // one idle edge after an ack, so acks never come back to back
   always_comb begin
      case (state_r)
         ST_IDLE:  state_nxt = offer ? ST_OFFER : ST_IDLE;
         ST_OFFER: state_nxt = offer ? ST_OFFER : ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // offered vector keeps tracking the winner until the core acks it
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         kind_r         <= KIND_RESET;
         exc_code_o     <= CODE_RESET;
         handler_addr_o <= HND_RESET;
         idx_r          <= '0;
         lvl_r          <= LVL_RESET;
         exc_is_intr_o  <= 1'b0;
         pc_valid_o     <= 1'b0;
      end else if (offer) begin
         kind_r         <= kind_nxt;
         exc_code_o     <= code_nxt;
         handler_addr_o <= hnd_nxt;
         idx_r          <= win_idx;
         lvl_r          <= win_lvl;
         exc_is_intr_o  <= !(kind_nxt inside {KIND_ILLOP, KIND_TRAP});
         pc_valid_o     <= (kind_nxt != KIND_RESET);
      end
   end

   assign exc_req_o = (state_r == ST_OFFER);

   // reset from the pin or the internal source always vectors to zero
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reset_pend_r <= 1'b1;
      end else if (soft_reset_i) begin
         reset_pend_r <= 1'b1;
      end else begin
         reset_pend_r <= reset_pend_r & ~clr_reset;
      end
   end

   // exceptions from the instruction stream: a new event beats the ack
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         illop_pend_r <= 1'b0;
         trap_pend_r  <= 1'b0;
         trap_vec_r   <= 5'h00;
      end else if (soft_reset_i) begin
         illop_pend_r <= 1'b0;
         trap_pend_r  <= 1'b0;
      end else begin
         illop_pend_r <= (illegal_opcode_exception_i | debug_exception_i)
                         | (illop_pend_r & ~clr_illop);
         trap_pend_r  <= trap_i | (trap_pend_r & ~clr_trap);
         // a second trap before the ack overwrites the nibble
         if (trap_i) begin
            trap_vec_r <= trap_vec_i;
         end
      end
   end

   // watchdog and filtered pin non-maskables, set wins here too
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wdt_pend_r <= 1'b0;
         nmi_pend_r <= 1'b0;
      end else if (soft_reset_i) begin
         wdt_pend_r <= 1'b0;
         nmi_pend_r <= 1'b0;
      end else begin
         wdt_pend_r <= watchdog_overflow_request_i | (wdt_pend_r & ~clr_wdt);
         nmi_pend_r <= nmi_evt | (nmi_pend_r & ~clr_nmi);
      end
   end

   // maskable pending flags, set wins over the ack clear
   generate
      for (g = 0; g < N_MSK; g++) begin : g_clr
         assign msk_clr[g] = clr_msk && (idx_r == SRC_W'(g));
      end
   endgenerate

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         msk_pend_r <= '0;
      end else if (soft_reset_i) begin
         msk_pend_r <= '0;
      end else begin
         msk_pend_r <= msk_set | (msk_pend_r & ~msk_clr);
      end
   end

   // in-service levels: eoi retires the best one before a new ack adds
   // limitation: eoi cannot name a level, it always retires the best one
   assign isr_clr = eoi_i ? isr_low : '0;
   assign isr_set = clr_msk ? (N_LVL'(1) << lvl_r) : '0;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         isr_r <= ISR_RESET;
      end else if (soft_reset_i) begin
         isr_r <= ISR_RESET;
      end else begin
         isr_r <= (isr_r & ~isr_clr) | isr_set;
      end
   end

   assign isr_o = isr_r;
endmodule
`default_nettype wire

// >>> src/iec_prio_arb_unused_placeholder_none.sv
// intentionally empty compile unit
`default_nettype none
`default_nettype wire

// >>> testbench/iec_monitor.sv
// port-level assertion checker for the interrupt/exception controller
`default_nettype none
module iec_monitor
   import iec_pkg::*;
(
   input wire logic                   core_clk_i,
   input wire logic                   rst_i,
   input wire logic                   watchdog_overflow_request_i,
   input wire logic [N_MSK-1:0]       mask_i,
   input wire logic [N_MSK*LVL_W-1:0] prio_i,
   input wire logic                   int_enable_i,
   input wire logic                   ack_i,
   input wire logic                   exc_req_o,
   input wire logic [15:0]            exc_code_o,
   input wire logic [31:0]            handler_addr_o,
   input wire logic                   exc_is_intr_o,
   input wire logic                   pc_valid_o,
   input wire logic [N_LVL-1:0]       isr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic             msk_w;
   logic [SRC_W-1:0] idx_w;
   logic [LVL_W-1:0] lvl_w;
   logic [N_MSK-1:0] mask_r;
   logic             en_r;
   assign msk_w = exc_code_o >= 16'h0080;
   assign idx_w = SRC_W'((exc_code_o - 16'h0080) >> 4);
   assign lvl_w = prio_i[LVL_W * idx_w +: LVL_W];
   // offer is registered, so gate it against last edge's mask
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mask_r <= '0;
         en_r   <= 1'b1;
      end else begin
         mask_r <= mask_i;
         en_r   <= int_enable_i;
      end
   end
   property p_reset_vec;
      exc_req_o && exc_code_o == 16'h0000 |-> handler_addr_o == 32'h0000_0000 && !pc_valid_o;
   endproperty
   a_reset_vec: assert property (p_reset_vec)
      else $error("reset vector wrong");
   property p_wdt_vec;
      exc_req_o && exc_code_o == 16'h0020 |-> handler_addr_o == 32'h0000_0020 && pc_valid_o;
   endproperty
   a_wdt_vec: assert property (p_wdt_vec)
      else $error("watchdog vector wrong");
   property p_nmi_vec;
      exc_req_o && exc_code_o == 16'h0030 |-> handler_addr_o == 32'h0000_0030 && exc_is_intr_o;
   endproperty
   a_nmi_vec: assert property (p_nmi_vec)
      else $error("pin vector wrong");
   property p_trap_vec;
      exc_req_o && exc_code_o[15:5] == 11'h002
         |-> handler_addr_o == {25'h0, 2'b10, exc_code_o[4], 4'h0} && !exc_is_intr_o;
   endproperty
   a_trap_vec: assert property (p_trap_vec)
      else $error("trap vector wrong");
   property p_ilg_vec;
      exc_req_o && exc_code_o == 16'h0060 |-> handler_addr_o == 32'h0000_0060 && !exc_is_intr_o;
   endproperty
   a_ilg_vec: assert property (p_ilg_vec)
      else $error("opcode trap vector wrong");
   property p_msk_vec;
      exc_req_o && msk_w |-> handler_addr_o == {16'h0000, exc_code_o} && exc_is_intr_o;
   endproperty
   a_msk_vec: assert property (p_msk_vec)
      else $error("maskable vector wrong");
   property p_mask_gate;
      $rose(exc_req_o) && msk_w |-> !mask_r[idx_w] && en_r;
   endproperty
   a_mask_gate: assert property (p_mask_gate)
      else $error("masked request offered");
   property p_isr_set;
      ack_i && exc_req_o && msk_w |=> isr_o[$past(lvl_w)];
   endproperty
   a_isr_set: assert property (p_isr_set)
      else $error("in-service level not set");
   property p_ack_drop;
      ack_i && exc_req_o |=> !exc_req_o;
   endproperty
   a_ack_drop: assert property (p_ack_drop)
      else $error("offer held after ack");
   property p_wdt_lat;
      $rose(watchdog_overflow_request_i) |-> ##[1:4] exc_req_o;
   endproperty
   a_wdt_lat: assert property (p_wdt_lat)
      else $error("watchdog not offered");
endmodule
`default_nettype wire

// >>> testbench/iec_core_model.sv
// processor core model: takes offered vectors, ends maskable handlers
`default_nettype none
module iec_core_model (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        exc_req_i,
   input  wire logic [15:0] exc_code_i,
   input  wire logic [31:0] handler_addr_i,
   input  wire logic        pc_valid_i,
   input  wire logic        slow_i,
   input  wire logic        auto_eoi_i,
   output logic             ack_o,
   output logic             eoi_o,
   output logic             taken_o,
   output logic [15:0]      taken_code_o,
   output logic [31:0]      taken_hnd_o,
   output logic             taken_pcv_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_cnt;
   // acks move on the falling edge so the rising edge sees them settled
   always @(negedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_o    <= 1'b0;
         eoi_o    <= 1'b0;
         wait_cnt <= 0;
      end else begin
         ack_o <= 1'b0;
         eoi_o <= taken_o && auto_eoi_i && taken_code_o >= 16'h0080;
         if (exc_req_i && !ack_o) begin
            if (wait_cnt >= (slow_i ? 3 : 0)) begin
               ack_o    <= 1'b1;
               wait_cnt <= 0;
            end else
               wait_cnt <= wait_cnt + 1;
         end
      end
   end
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         taken_o <= 1'b0;
      end else begin
         taken_o <= ack_o && exc_req_i;
         if (ack_o && exc_req_i) begin
            taken_code_o <= exc_code_i;
            taken_hnd_o  <= handler_addr_i;
            taken_pcv_o  <= pc_valid_i;
         end
      end
   end
endmodule
`default_nettype wire

// >>> testbench/iec_interrupt_arbiter_test.sv
// self-checking bench for the interrupt/exception controller
`default_nettype none
module iec_interrupt_arbiter_test
   import iec_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic                     clk, rst, srst, lvi, nmi, wdt, trap, ilg, dbg, en;
   logic                     ack, eoi, m_eoi, tb_eoi, slow, aeoi, req, intr, pcv, tk, tpcv;
   logic [N_INT-2:0]         periph;
   logic [N_EXT-1:0]         pins;
   logic [N_EXT*2-1:0]       esel;
   logic [1:0]               nsel;
   logic [4:0]               tvec;
   logic [N_MSK-1:0]         mask;
   logic [N_MSK*LVL_W-1:0]   prio;
   logic [15:0]              code, tcode;
   logic [31:0]              hnd, thnd;
   logic [N_LVL-1:0]         isr;
   int                       seed = 60485;
   int                       mismatches = 0;
   int                       samples_checked = 0;
   int                       a, b, la, lb;
   assign eoi = m_eoi | tb_eoi;
   iec_interrupt_arbiter uut (.core_clk_i(clk), .rst_i(rst), .soft_reset_i(srst),
      .low_voltage_request_i(lvi), .periph_req_i(periph), .ext_pin_i(pins),
      .ext_edge_sel_i(esel), .nmi_pin_i(nmi), .nmi_edge_sel_i(nsel),
      .watchdog_overflow_request_i(wdt), .trap_i(trap), .trap_vec_i(tvec),
      .illegal_opcode_exception_i(ilg), .debug_exception_i(dbg), .mask_i(mask),
      .prio_i(prio), .int_enable_i(en), .ack_i(ack), .eoi_i(eoi), .exc_req_o(req),
      .exc_code_o(code), .handler_addr_o(hnd), .exc_is_intr_o(intr), .pc_valid_o(pcv),
      .isr_o(isr));
   iec_core_model u_core (.core_clk_i(clk), .rst_i(rst), .exc_req_i(req), .exc_code_i(code),
      .handler_addr_i(hnd), .pc_valid_i(pcv), .slow_i(slow), .auto_eoi_i(aeoi), .ack_o(ack),
      .eoi_o(m_eoi), .taken_o(tk), .taken_code_o(tcode), .taken_hnd_o(thnd),
      .taken_pcv_o(tpcv));
   function automatic logic [15:0] mcode(input int i);
      mcode = 16'h0080 + 16'(i) * 16'h0010;
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", what, e, g);
      end
   endtask
   // handler is the code with its low nibble cleared, for every source
   task automatic take(input logic [15:0] c, input logic pv);
      int n;
      n = 0;
      while (tk !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk("taken", 1, tk);
      chk("code", c, tcode);
      chk("handler", {16'h0000, c[15:4], 4'h0}, thnd);
      chk("pc valid", pv, tpcv);
      @(negedge clk);
   endtask
   task automatic none(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(negedge clk);
         seen = seen | (req !== 1'b0);
      end
      chk("idle offer", 0, seen);
   endtask
   task automatic pulse(input int s);
      case (s)
         0: wdt = 1'b1;
         1: trap = 1'b1;
         2: ilg = 1'b1;
         3: dbg = 1'b1;
         4: lvi = 1'b1;
         5: srst = 1'b1;
         6: ;
         default: periph[s-10] = 1'b1;
      endcase
      @(negedge clk);
      {wdt, trap, ilg, dbg, lvi, srst} = '0;
      periph = '0;
   endtask
   task automatic pin(input int k, input logic v, input int n);
      if (k == 8)
         nmi = v;
      else
         pins[k] = v;
      repeat (n) @(negedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // roughly sixty times the expected run length
   initial begin
      #120000;
      mismatches++;
      $display("watchdog expired");
      tally_and_finish();
   end
   initial begin
      rst = 1'b1;
      {srst, lvi, nmi, wdt, trap, ilg, dbg, tb_eoi, slow} = '0;
      {periph, pins, tvec, mask} = '0;
      prio = '1;
      esel = 16'h5555;
      nsel = EDGE_RISE;
      en = 1'b1;
      aeoi = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      take(16'h0000, 1'b0);
      pulse(0);
      take(16'h0020, 1'b1);
      pin(8, 1'b1, 2);
      pin(8, 1'b0, 1);
      none(20);
      pin(8, 1'b1, 8);
      take(16'h0030, 1'b1);
      $display("non-maskable tests done");
      for (int v = 0; v < 32; v++) begin
         tvec = 5'(v);
         slow = v[0];
         pulse(1);
         take(16'h0040 + 16'(v), 1'b1);
      end
      slow = 1'b0;
      pulse(2);
      take(16'h0060, 1'b1);
      pulse(3);
      take(16'h0060, 1'b1);
      pulse(4);
      take(16'h0080, 1'b1);
      $display("exception tests done");
      for (int k = 0; k < 8; k++) begin
         pin(k, 1'b1, 8);
         take(mcode(k + 1), 1'b1);
      end
      esel[1:0] = EDGE_FALL;
      pin(0, 1'b0, 8);
      take(mcode(1), 1'b1);
      esel[3:2] = EDGE_BOTH;
      pin(1, 1'b0, 8);
      take(mcode(2), 1'b1);
      esel[5:4] = EDGE_NONE;
      pin(2, 1'b0, 8);
      none(10);
      $display("pin tests done");
      mask[9] = 1'b1;
      pulse(10);
      none(20);
      mask[9] = 1'b0;
      take(mcode(9), 1'b1);
      en = 1'b0;
      pulse(11);
      none(10);
      en = 1'b1;
      take(mcode(10), 1'b1);
      $display("mask tests done");
      for (int i = 0; i < 12; i++) begin
         a = $unsigned($random(seed)) % 58;
         b = (a + 1 + $unsigned($random(seed)) % 57) % 58;
         la = $unsigned($random(seed)) % 8;
         lb = $unsigned($random(seed)) % 8;
         if (i < 3)
            lb = la;
         prio[3 * (9 + a) +: 3] = 3'(la);
         prio[3 * (9 + b) +: 3] = 3'(lb);
         periph[a] = 1'b1;
         periph[b] = 1'b1;
         pulse(6);
         if (la < lb || (la == lb && a < b)) begin
            take(mcode(9 + a), 1'b1);
            take(mcode(9 + b), 1'b1);
         end else begin
            take(mcode(9 + b), 1'b1);
            take(mcode(9 + a), 1'b1);
         end
      end
      $display("priority tests done");
      prio = '1;
      aeoi = 1'b0;
      prio[27 +: 3] = 3'h5;
      prio[30 +: 3] = 3'h2;
      prio[33 +: 3] = 3'h5;
      pulse(10);
      take(mcode(9), 1'b1);
      pulse(12);
      none(15);
      pulse(11);
      take(mcode(10), 1'b1);
      chk("in-service", 8'h24, isr);
      pulse(0);
      take(16'h0020, 1'b1);
      tb_eoi = 1'b1;
      @(negedge clk);
      tb_eoi = 1'b0;
      none(10);
      tb_eoi = 1'b1;
      @(negedge clk);
      tb_eoi = 1'b0;
      take(mcode(11), 1'b1);
      $display("nesting tests done");
      pulse(5);
      take(16'h0000, 1'b0);
      chk("in-service", 8'h00, isr);
      $display("soft reset test done");
      tally_and_finish();
   end
endmodule
bind iec_interrupt_arbiter iec_monitor u_mon (
   .core_clk_i(core_clk_i),
   .rst_i(rst_i),
   .watchdog_overflow_request_i(watchdog_overflow_request_i),
   .mask_i(mask_i),
   .prio_i(prio_i),
   .int_enable_i(int_enable_i),
   .ack_i(ack_i),
   .exc_req_o(exc_req_o),
   .exc_code_o(exc_code_o),
   .handler_addr_o(handler_addr_o),
   .exc_is_intr_o(exc_is_intr_o),
   .pc_valid_o(pc_valid_o),
   .isr_o(isr_o)
);
`default_nettype wire
